// ===== core/usu_pkg.sv
// Operation
// - a data register write in a shift cycle keeps the written value, no shift
// - output pin follows data bit 7 via latch, half-cycle open on external clock
// - with outputs disabled, data and clock inputs still shift and count
// - two-wire mode sets start flag on each detected start condition
// - modes 00/01, external clock, strobe bit zero: any clock edge sets start flag
// - start flag clears only by writing one; clearing frees the start clock hold
// - start interrupt while start flag, its enable and global enable are set
// - two-wire start detection works without clock so it can wake from any sleep
// - overflow flag set on 15 to 0 wrap; interrupt with its enables set
// - overflow flag clears only by writing one; clearing frees overflow clock hold
// - overflow interrupt can wake the processor from idle
// - two-wire stop condition sets stop flag, cleared by writing one, no interrupt
// - collision bit is one while data bit 7 differs from data pin level
// - status bits 3..0 show the counter, readable and writable by software
// - counter steps once per clock from edge detector, timer overflow or strobe
// - external clock with clock strobe written one: toggle strobe clocks counter
// - counter clocked from the pin counts both rising and falling edges
// - after start, slave holds clock low from master's falling edge until flag clear
// - two-wire slave samples data into the register on clock rising edge
// - after eight bits counter overflows and clock is held low until released
// - wire mode 00 disables outputs and hold, clock edges still set start flag; 01 three-wire; 10 two-wire
// - two-wire: data line pulled low when register output or port bit is zero
package usu_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned    USU_AW        = 4;
  localparam logic [3:0]     USU_OFS_DATA  = 4'h0;
  localparam logic [3:0]     USU_OFS_STAT  = 4'h4;
  localparam logic [3:0]     USU_OFS_CTRL  = 4'h8;
  localparam logic [7:0]     USU_DATA_RST  = 8'h00;
  localparam logic [3:0]     USU_CNT_RST   = 4'h0;
  localparam logic [3:0]     USU_CNT_MAX   = 4'hf;

  // status bit positions
  localparam int unsigned    ST_START      = 7;
  localparam int unsigned    ST_OVF        = 6;
  localparam int unsigned    ST_STOP       = 5;
  localparam int unsigned    ST_COLL       = 4;
  localparam int unsigned    ST_CNT_HI     = 3;

  // control bit positions
  localparam int unsigned    CT_SIE        = 7;
  localparam int unsigned    CT_OIE        = 6;
  localparam int unsigned    CT_WM_HI      = 5;
  localparam int unsigned    CT_WM_LO      = 4;
  localparam int unsigned    CT_CS_HI      = 3;
  localparam int unsigned    CT_CS_LO      = 2;
  localparam int unsigned    CT_CLK        = 1;
  localparam int unsigned    CT_TC         = 0;

  localparam int unsigned    SHIFT_MSB     = 7;
  localparam int unsigned    SYNC_STAGES   = 3;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  localparam logic [1:0]     WM_OFF        = 2'h0;
  localparam logic [1:0]     WM_THREE      = 2'h1;
  localparam logic [1:0]     WM_TWO        = 2'h2;
  localparam logic [1:0]     CS_SOFT       = 2'h0;
  localparam logic [1:0]     CS_TIMER      = 2'h1;
  localparam logic [1:0]     CS_EXT_POS    = 2'h2;
  localparam logic [1:0]     CS_EXT_NEG    = 2'h3;

  typedef struct packed {
    logic       sie;
    logic       oie;
    logic [1:0] wm;
    logic [1:0] cs;
  } usu_ctrl_t;

  localparam usu_ctrl_t      USU_CTRL_RST  = '{sie: 1'b0, oie: 1'b0, wm: WM_OFF, cs: CS_SOFT};

  typedef struct packed {
    logic out;
    logic oe;
  } usu_pin_t;

  localparam usu_pin_t       USU_PIN_RST   = '{out: 1'b0, oe: 1'b0};

endpackage

// ===== core/usu_core.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module usu_core
  import usu_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [USU_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              serial_data_input_pin,
  input  wire logic              serial_clock_pin,
  input  wire logic              port_data_bit,
  input  wire logic              ddr_data_bit,
  input  wire logic              port_clock_bit,
  input  wire logic              ddr_clock_bit,
  input  wire logic              ddr_do_bit,
  input  wire logic              timer0_overflow,
  input  wire logic              global_int_enable,
  output usu_pin_t               data_out_pin,
  output usu_pin_t               sda_pin,
  output usu_pin_t               scl_pin,
  output logic                   port_clock_toggle,
  output logic                   start_irq,
  output logic                   overflow_irq,
  output logic                   wake_any,
  output logic                   wake_idle
);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        acc;
  logic        mapped;
  logic        data_wr;
  logic        stat_wr;
  logic        ctrl_wr;
  logic [31:0] prdata_r;
  logic [31:0] rd_nxt;

  assign mapped  = (paddr == USU_OFS_DATA) || (paddr == USU_OFS_STAT) || (paddr == USU_OFS_CTRL);
  assign acc     = psel && penable;
  assign pready  = acc;
  assign pslverr = acc && !mapped;
  assign prdata  = prdata_r;
  assign data_wr = acc && pwrite && (paddr == USU_OFS_DATA);
  assign stat_wr = acc && pwrite && (paddr == USU_OFS_STAT);
  assign ctrl_wr = acc && pwrite && (paddr == USU_OFS_CTRL);

  // ----------------------------------------------------------------
  // pin synchronisers, index 0 data line, index 1 clock line
  // ----------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;
  logic [1:0] pin_fall;

  assign pin_raw = {serial_clock_pin, serial_data_input_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] sync_r;
      logic                   agree;
      logic                   flt_r;
      // lines idle high: a zero here would fake a falling edge after reset
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync_r <= '1;
        end else begin
          sync_r <= {sync_r[SYNC_STAGES-2:0], pin_raw[gi]};
        end
      end
      // only stages two and three are compared; stage one may be metastable
      assign agree        = (sync_r[1] == sync_r[2]);
      assign pin_rise[gi] = agree && sync_r[1] && !flt_r;
      assign pin_fall[gi] = agree && !sync_r[1] && flt_r;
      assign pin_lvl[gi]  = flt_r;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          flt_r <= 1'b1;
        end else if (agree) begin
          flt_r <= sync_r[1];
        end
      end
    end
  endgenerate

  logic sda_lvl;
  logic scl_lvl;
  logic sda_rise;
  logic sda_fall;
  logic scl_rise;
  logic scl_fall;

  assign sda_lvl  = pin_lvl[0];
  assign scl_lvl  = pin_lvl[1];
  assign sda_rise = pin_rise[0];
  assign sda_fall = pin_fall[0];
  assign scl_rise = pin_rise[1];
  assign scl_fall = pin_fall[1];

  // ----------------------------------------------------------------
  // control register and strobes
  // ----------------------------------------------------------------
  usu_ctrl_t  ctrl_r;
  logic       clk_mode_r;
  logic [1:0] cs_now;
  logic       clk_mode_now;
  logic       strobe_clk;
  logic       strobe_tc;
  logic       two_wire;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r     <= USU_CTRL_RST;
      clk_mode_r <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_r     <= '{sie: pwdata[CT_SIE], oie: pwdata[CT_OIE], wm: pwdata[CT_WM_HI:CT_WM_LO],
                      cs: pwdata[CT_CS_HI:CT_CS_LO]};
      clk_mode_r <= pwdata[CT_CLK];
    end
  end

  // a control write clocks with the clock settings it carries; wire mode applies next cycle
  assign cs_now       = ctrl_wr ? pwdata[CT_CS_HI:CT_CS_LO] : ctrl_r.cs;
  assign clk_mode_now = ctrl_wr ? pwdata[CT_CLK] : clk_mode_r;
  assign strobe_clk   = ctrl_wr && pwdata[CT_CLK];
  assign strobe_tc    = ctrl_wr && pwdata[CT_TC];
  assign two_wire     = (ctrl_r.wm == WM_TWO);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_clock_toggle <= 1'b0;
    end else begin
      port_clock_toggle <= strobe_tc;
    end
  end

  // ----------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------
  logic shift_tick;
  logic count_tick;

  always_comb begin
    case (cs_now)
      CS_SOFT:    shift_tick = strobe_clk;
      CS_TIMER:   shift_tick = timer0_overflow;
      CS_EXT_POS: shift_tick = scl_rise;
      CS_EXT_NEG: shift_tick = scl_fall;
      default:    shift_tick = 1'b0;
    endcase
  end

  always_comb begin
    if (!cs_now[1]) begin
      count_tick = shift_tick;
    end else if (clk_mode_now) begin
      count_tick = strobe_tc;
    end else begin
      count_tick = scl_rise || scl_fall;
    end
  end

  // ----------------------------------------------------------------
  // shift register and counter
  // ----------------------------------------------------------------
  logic [7:0] data_r;
  logic [3:0] cnt_r;
  logic       ovf_set;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_r <= USU_DATA_RST;
    end else if (data_wr) begin
      data_r <= pwdata[7:0];
    end else if (shift_tick) begin
      data_r <= {data_r[SHIFT_MSB-1:0], sda_lvl};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= USU_CNT_RST;
    end else if (stat_wr) begin
      cnt_r <= pwdata[ST_CNT_HI:0];
    end else if (count_tick) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // a counter write in the same cycle suppresses the step and its wrap
  assign ovf_set = count_tick && !stat_wr && (cnt_r == USU_CNT_MAX);

  // ----------------------------------------------------------------
  // start and stop detection, flags
  // ----------------------------------------------------------------
  logic start_flag_r;
  logic ovf_flag_r;
  logic stop_flag_r;
  logic start_set;
  logic stop_set;
  logic start_clr;
  logic ovf_clr;
  logic stop_clr;

  // filtered levels share latency, so data changes are judged against a settled clock
  assign start_set = (two_wire && sda_fall && scl_lvl)
                     || (!two_wire && ctrl_r.cs[1] && !clk_mode_r && (scl_rise || scl_fall));
  assign stop_set  = two_wire && sda_rise && scl_lvl;
  assign start_clr = stat_wr && pwdata[ST_START];
  assign ovf_clr   = stat_wr && pwdata[ST_OVF];
  assign stop_clr  = stat_wr && pwdata[ST_STOP];

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_flag_r <= 1'b0;
    end else begin
      start_flag_r <= start_set || (start_flag_r && !start_clr);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ovf_flag_r <= 1'b0;
    end else begin
      ovf_flag_r <= ovf_set || (ovf_flag_r && !ovf_clr);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stop_flag_r <= 1'b0;
    end else begin
      stop_flag_r <= stop_set || (stop_flag_r && !stop_clr);
    end
  end

  // ----------------------------------------------------------------
  // clock hold
  // ----------------------------------------------------------------
  logic start_hold_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_hold_r <= 1'b0;
    end else if (!two_wire || !start_flag_r) begin
      start_hold_r <= 1'b0;
    end else if (scl_fall) begin
      start_hold_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // output latch and pin drivers
  // ----------------------------------------------------------------
  logic out_hold_r;
  logic latch_open;
  logic latch_bit;

  // open in the half of the cycle before the shifting edge
  assign latch_open = !ctrl_r.cs[1] || (scl_lvl == ctrl_r.cs[0]);
  assign latch_bit  = latch_open ? data_r[SHIFT_MSB] : out_hold_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_hold_r <= 1'b0;
    end else begin
      out_hold_r <= latch_bit;
    end
  end

  // pins are registered: one cycle from cause to pad
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_out_pin <= USU_PIN_RST;
      sda_pin      <= USU_PIN_RST;
      scl_pin      <= USU_PIN_RST;
    end else begin
      data_out_pin <= '{out: latch_bit, oe: (ctrl_r.wm == WM_THREE) && ddr_do_bit};
      sda_pin      <= '{out: 1'b0, oe: two_wire && ddr_data_bit && (!latch_bit || !port_data_bit)};
      scl_pin      <= '{out: 1'b0, oe: two_wire && ddr_clock_bit &&
                        (!port_clock_bit || start_hold_r || ovf_flag_r)};
    end
  end

  // ----------------------------------------------------------------
  // interrupts and wake
  // ----------------------------------------------------------------
  assign start_irq    = start_flag_r && ctrl_r.sie && global_int_enable;
  assign overflow_irq = ovf_flag_r && ctrl_r.oie && global_int_enable;
  assign wake_idle    = overflow_irq;
  // raw pins, no clock needed: lets a stopped oscillator be restarted
  assign wake_any     = start_irq || (two_wire && ctrl_r.sie && global_int_enable
                        && serial_clock_pin && !serial_data_input_pin);

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [7:0] status_v;

  assign status_v = {start_flag_r, ovf_flag_r, stop_flag_r,
                     data_r[SHIFT_MSB] ^ sda_lvl, cnt_r};

  always_comb begin
    rd_nxt = '0;
    case (paddr)
      USU_OFS_DATA: rd_nxt[7:0] = data_r;
      USU_OFS_STAT: rd_nxt[7:0] = status_v;
      USU_OFS_CTRL: rd_nxt[7:0] = {ctrl_r.sie, ctrl_r.oie, ctrl_r.wm, ctrl_r.cs, 2'b00};
      default:      rd_nxt      = '0;
    endcase
  end

  // captured in the setup cycle; status can move on one cycle before pready
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      prdata_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_write_beats_shift: assert property (data_wr |=> data_r == $past(pwdata[7:0]))
    else $error("data write lost to a shift");
  a_count_steps: assert property (count_tick && !stat_wr |=> cnt_r == 4'($past(cnt_r) + 4'h1))
    else $error("counter did not step");
  a_wrap_sets_ovf: assert property (count_tick && !stat_wr && cnt_r == USU_CNT_MAX
                                    |=> ovf_flag_r && cnt_r == USU_CNT_RST)
    else $error("wrap did not set overflow flag");
  a_start_sticky: assert property (start_flag_r && !start_clr |=> start_flag_r)
    else $error("start flag dropped without clear");
  a_ovf_release: assert property (ovf_flag_r && ovf_clr && !ovf_set |=> !ovf_flag_r)
    else $error("overflow flag not cleared");
  a_start_hold: assert property (two_wire && start_flag_r && !start_clr && scl_fall
                                 |=> start_hold_r)
    else $error("start hold not taken");
  a_stop_flag: assert property (stop_set |=> stop_flag_r && !$past(start_set && two_wire))
    else $error("stop flag not set");
  a_off_no_drive: assert property (ctrl_r.wm == WM_OFF ##1 ctrl_r.wm == WM_OFF
                                   |-> !sda_pin.oe && !scl_pin.oe && !data_out_pin.oe)
    else $error("outputs driven with wire mode off");
  a_edge_start: assert property (!two_wire && ctrl_r.cs == CS_EXT_NEG && !clk_mode_r && scl_rise
                                 |=> start_flag_r)
    else $error("clock edge did not set start flag");
  a_start_irq: assert property ($rose(start_flag_r) && ctrl_r.sie && global_int_enable
                                |-> start_irq && wake_any)
    else $error("start interrupt missing");
  a_start_detect: assert property (two_wire && sda_fall && scl_lvl |=> start_flag_r)
    else $error("start condition not flagged");
  a_stop_sticky: assert property (stop_flag_r && !stop_clr |=> stop_flag_r)
    else $error("stop flag dropped without clear");
  a_ovf_hold: assert property (two_wire && ddr_clock_bit && ovf_flag_r |=> scl_pin.oe)
    else $error("clock not held after overflow");
  a_sda_pull: assert property (two_wire && ddr_data_bit && !port_data_bit |=> sda_pin.oe)
    else $error("data line not pulled low");
  a_count_load: assert property (stat_wr |=> cnt_r == $past(pwdata[ST_CNT_HI:0]))
    else $error("counter write lost");
  a_ovf_irq: assert property (ovf_flag_r && ctrl_r.oie && global_int_enable
                              |-> overflow_irq && wake_idle)
    else $error("overflow interrupt missing");

endmodule

// ===== testbench/usu_bus_master.sv
`timescale 1ns/100ps
module usu_bus_master (
  output logic      scl_low,
  output logic      sda_low,
  input  wire logic scl_line
);
  // --------------------------------
  // two-wire master, bit-banged lines
  // --------------------------------
  localparam realtime HALF = 62.5;
  int misses;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    misses  = 0;
  end
  // start: data falls with clock high; stop: data rises with clock high
  task automatic set_lines(input logic s, input logic d);
    scl_low <= !s;
    sda_low <= !d;
    #HALF;
  endtask
  // a slave may stretch the low phase, so wait until the clock really rises
  task automatic bit_out(input logic b);
    int n;
    n = 0;
    sda_low <= !b;
    #HALF;
    scl_low <= 1'b0;
    while (scl_line !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (n == 5000) misses++;
    #HALF;
    scl_low <= 1'b1;
    #HALF;
  endtask
endmodule

// ===== testbench/universal_serial_shift_unit_tb.sv
`timescale 1ns/100ps
module universal_serial_shift_unit_tb
  import usu_pkg::*;
;
  localparam logic [3:0] AD = USU_OFS_DATA;
  localparam logic [3:0] AS = USU_OFS_STAT;
  localparam logic [3:0] AC = USU_OFS_CTRL;
  localparam logic [7:0] RX_BYTE = 8'ha5;
  logic        clk, reset, psel, penable, pwrite, tmr_arm, timer0_overflow, global_int_enable;
  logic        port_data_bit, ddr_data_bit, port_clock_bit, ddr_clock_bit, ddr_do_bit;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata, rd_r;
  logic        pready, pslverr, err_r, port_clock_toggle, start_irq, overflow_irq, wake_any, wake_idle;
  logic        m_scl_low, m_sda_low, scl_line, sda_line;
  usu_pin_t    data_out_pin, sda_pin, scl_pin;
  int          err_total, checks_done, tog_cnt, tog0;

  // open-drain lines with pull-ups
  assign scl_line = !(m_scl_low || scl_pin.oe === 1'b1);
  assign sda_line = !(m_sda_low || sda_pin.oe === 1'b1);

  usu_core i_dut (
    .clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_data_input_pin(sda_line), .serial_clock_pin(scl_line), .port_data_bit, .ddr_data_bit,
    .port_clock_bit, .ddr_clock_bit, .ddr_do_bit, .timer0_overflow, .global_int_enable,
    .data_out_pin, .sda_pin, .scl_pin, .port_clock_toggle, .start_irq, .overflow_irq, .wake_any, .wake_idle
  );
  usu_bus_master i_mst (.scl_low(m_scl_low), .sda_low(m_sda_low), .scl_line(scl_line));

  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) if (port_clock_toggle === 1'b1) tog_cnt++;

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge clk);
    penable         <= 1'b1;
    timer0_overflow <= tmr_arm;
    @(posedge clk);
    timer0_overflow <= 1'b0;
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      err_total++;
      end_sim();
    end
    rd_r  = prdata;
    err_r = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk(rd_r & {24'hff_ffff, m}, {24'h00_0000, exp});
  endtask
  // pin change is seen three edges late, acted on one edge later, driven one more
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_regs();
    rdc(AD, 8'h00, 8'hff);
    rdc(AS, 8'h00, 8'hef);
    rdc(AC, 8'h00, 8'hff);
    apb(1'b1, 4'hc, 8'hff);
    chkb(err_r, 1'b1);
    apb(1'b0, 4'hc, 8'h00);
    chkb(err_r, 1'b1);
    chk(rd_r, 32'h0000_0000);
  endtask
  task automatic t_soft();
    apb(1'b1, AD, 8'h81);
    apb(1'b1, AC, 8'h02);
    rdc(AD, 8'h03, 8'hff);
    rdc(AS, 8'h01, 8'h4f);
    apb(1'b1, AS, 8'h0f);
    apb(1'b1, AC, 8'h42);
    rdc(AS, 8'h40, 8'h4f);
    rdc(AC, 8'h40, 8'hff);
    chkb(overflow_irq, 1'b1);
    chkb(wake_idle, 1'b1);
    global_int_enable <= 1'b0;
    apb(1'b1, AS, 8'h00);
    chkb(overflow_irq, 1'b0);
    rdc(AS, 8'h40, 8'h4f);
    apb(1'b1, AS, 8'h40);
    rdc(AS, 8'h00, 8'h4f);
    global_int_enable <= 1'b1;
  endtask
  task automatic t_timer();
    apb(1'b1, AC, 8'h04);
    apb(1'b1, AS, 8'h00);
    @(posedge clk);
    timer0_overflow <= 1'b1;
    @(posedge clk);
    timer0_overflow <= 1'b0;
    rdc(AS, 8'h01, 8'h0f);
    tmr_arm = 1'b1;
    apb(1'b1, AD, 8'h5a);
    tmr_arm = 1'b0;
    rdc(AD, 8'h5a, 8'hff);
    rdc(AS, 8'h02, 8'h0f);
  endtask
  task automatic t_latch();
    ddr_do_bit <= 1'b1;
    apb(1'b1, AC, 8'h10);
    apb(1'b1, AD, 8'h80);
    settle();
    chkb(data_out_pin.out, 1'b1);
    chkb(data_out_pin.oe, 1'b1);
    apb(1'b1, AC, 8'h18);
    apb(1'b1, AD, 8'h00);
    settle();
    chkb(data_out_pin.out, 1'b1);
    i_mst.set_lines(1'b0, 1'b1);
    settle();
    chkb(data_out_pin.out, 1'b0);
    i_mst.set_lines(1'b1, 1'b1);
  endtask
  task automatic t_edges();
    logic [7:0] codes [2];
    codes = '{8'h1c, 8'h18};
    apb(1'b1, AC, 8'h08);
    apb(1'b1, AS, 8'he0);
    repeat (2) begin
      i_mst.set_lines(1'b0, 1'b1);
      i_mst.set_lines(1'b1, 1'b1);
    end
    settle();
    rdc(AS, 8'h84, 8'h8f);
    foreach (codes[k]) begin
      apb(1'b1, AC, codes[k]);
      apb(1'b1, AS, 8'h80);
      i_mst.set_lines(1'b0, 1'b1);
      i_mst.set_lines(1'b1, 1'b1);
      settle();
      rdc(AS, 8'h82, 8'h8f);
    end
    apb(1'b1, AS, 8'h80);
    tog0 = tog_cnt;
    apb(1'b1, AC, 8'h0b);
    settle();
    rdc(AS, 8'h01, 8'h8f);
    chk(32'(tog_cnt), 32'(tog0 + 1));
    i_mst.set_lines(1'b0, 1'b1);
    settle();
    rdc(AS, 8'h00, 8'h80);
    i_mst.set_lines(1'b1, 1'b1);
  endtask
  task automatic t_two();
    ddr_data_bit  <= 1'b1;
    ddr_clock_bit <= 1'b1;
    apb(1'b1, AD, 8'hff);
    apb(1'b1, AC, 8'h00);
    apb(1'b1, AS, 8'he0);
    apb(1'b1, AC, 8'ha8);
    settle();
    chkb(sda_pin.oe, 1'b0);
    i_mst.set_lines(1'b1, 1'b0);
    settle();
    rdc(AS, 8'h80, 8'he0);
    chkb(start_irq, 1'b1);
    chkb(wake_any, 1'b1);
    i_mst.set_lines(1'b0, 1'b0);
    settle();
    chkb(scl_pin.oe, 1'b1);
    apb(1'b1, AS, 8'h80);
    settle();
    chkb(scl_pin.oe, 1'b0);
    chkb(start_irq, 1'b0);
    for (int i = 7; i >= 0; i--) i_mst.bit_out(RX_BYTE[i]);
    settle();
    rdc(AD, RX_BYTE, 8'hff);
    rdc(AS, 8'h40, 8'h4f);
    chkb(scl_pin.oe, 1'b1);
    apb(1'b1, AD, 8'h00);
    apb(1'b1, AS, 8'h4e);
    settle();
    chkb(sda_pin.oe, 1'b1);
    chkb(scl_pin.oe, 1'b0);
    i_mst.bit_out(1'b1);
    settle();
    rdc(AS, 8'h40, 8'h4f);
    chkb(scl_pin.oe, 1'b1);
    apb(1'b1, AD, 8'hff);
    settle();
    chkb(sda_pin.oe, 1'b0);
    rdc(AS, 8'h00, 8'h10);
    port_data_bit <= 1'b0;
    settle();
    chkb(sda_pin.oe, 1'b1);
    rdc(AS, 8'h10, 8'h10);
    port_data_bit <= 1'b1;
    apb(1'b1, AS, 8'h40);
    i_mst.set_lines(1'b0, 1'b0);
    i_mst.set_lines(1'b1, 1'b0);
    chkb(wake_any, 1'b1);
    i_mst.set_lines(1'b1, 1'b1);
    settle();
    rdc(AS, 8'h20, 8'h20);
    chkb(start_irq, 1'b0);
    apb(1'b1, AC, 8'h08);
    apb(1'b1, AD, 8'h00);
    settle();
    chkb(sda_pin.oe, 1'b0);
    chkb(data_out_pin.oe, 1'b0);
    chk(32'(i_mst.misses), 32'h0000_0000);
  endtask

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, tmr_arm, timer0_overflow, ddr_data_bit, ddr_clock_bit, ddr_do_bit} = 8'h00;
    {port_data_bit, port_clock_bit, global_int_enable} = 3'h7;
    paddr = 4'h0;
    pwdata = 32'h0000_0000;
    err_total = 0;
    checks_done = 0;
    tog_cnt = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_soft();
    t_timer();
    t_latch();
    t_edges();
    t_two();
    end_sim();
  end
  initial begin
    #200_000;
    err_total++;
    end_sim();
  end
endmodule
